/* File: smd_pkg.sv */
package smd_pkg;

  localparam longint CLK_HZ = 64'd20_000_000;

  // serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int FRAME_WRITE_BIT = 15;
  localparam int FRAME_ADDR_HI = 14;
  localparam int FRAME_ADDR_LO = 8;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] FRAME_CNT_MAX = 5'h1F;

  // byte addresses of the register words
  localparam logic [6:0] ADDR_NVM_CNT = 7'h00;
  localparam logic [6:0] ADDR_DAC = 7'h30;
  localparam logic [6:0] ADDR_MISC = 7'h34;
  localparam logic [6:0] ADDR_DIAG = 7'h3C;
  localparam logic [6:0] ADDR_GCMD = 7'h3E;

  // misc_control fields
  localparam int MISC_DR_LINE = 0;
  localparam int MISC_DR_POL = 1;
  localparam int MISC_DR_EN = 2;
  localparam int MISC_ST_POS = 8;
  localparam int MISC_ST_NEG = 9;
  localparam int MISC_SELFTEST = 10;
  localparam int MISC_MEMTEST = 11;
  localparam logic [15:0] MISC_RESET = 16'h0006;

  // analog_out_code
  localparam int DAC_W = 12;
  localparam logic [15:0] DAC_RESET = 16'h0000;
  localparam logic [15:0] DAC_MASK = 16'h0FFF;

  // global_command fields
  localparam int GCMD_DAC_LATCH = 2;
  localparam int GCMD_NVM_UPDATE = 3;

  // diagnostic_flags fields
  localparam int DIAG_SUP_LOW = 0;
  localparam int DIAG_SUP_HIGH = 1;
  localparam int DIAG_NVM_FAIL = 2;
  localparam int DIAG_SPI_FAIL = 3;
  localparam int DIAG_OVERRANGE = 4;
  localparam int DIAG_SELFTEST = 5;
  localparam int DIAG_MEMTEST = 6;
  localparam int DIAG_ALARM1 = 8;
  localparam int DIAG_ALARM2 = 9;
  localparam logic [15:0] DIAG_RESET = 16'h0000;
  localparam logic [15:0] DIAG_STICKY_MASK = 16'h037C;

  localparam logic [15:0] NVM_CNT_RESET = 16'h0000;

  // data-ready pulse timing
  localparam longint DRDY_MIN_US = 64'd100;
  localparam longint DRDY_MAX_US = 64'd200;
  localparam longint DRDY_MIN_CYC =
    (DRDY_MIN_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;
  localparam longint DRDY_MAX_CYC = (DRDY_MAX_US * CLK_HZ) / 64'd1_000_000;
  localparam int DRDY_CNT_W = 12;
  localparam logic [DRDY_CNT_W-1:0] DRDY_PULSE_CYC =
    DRDY_CNT_W'((DRDY_MIN_CYC + DRDY_MAX_CYC) / 64'd2);
  localparam logic [DRDY_CNT_W-1:0] DRDY_CNT_ZERO = 12'h000;

  typedef enum {
    TS_IDLE,
    TS_MEM_WAIT,
    TS_ST_POS,
    TS_ST_NEG,
    TS_ST_DONE
  } smd_test_t;

endpackage

/* File: smd_sync.sv */
module smd_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  input wire logic [W-1:0] i_reset_val,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_next;

  // the first stage feeds only the second stage
  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  // reset value comes from a tied constant at the instance
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= i_reset_val;
      sync_reg <= i_reset_val;
    end else if (i_ce) begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;
endmodule

/* File: smd_misc_diag.sv */
// Operation
// - low misc bits configure data-ready enable/polarity/line
// - one 100 to 200 us pulse per sample
// - misc control resets to 0x0006
// - bit 11 starts memory test, self-clears
// - checksum mismatch loads diagnostic bit 6
// - bit 10 runs self-test, failure sets bit 5
// - bits 9/8 hold negative/positive stimulus manually
// - analog code is 12-bit offset binary
// - analog code reaches output only on latch
// - read-only counter counts nonvolatile write cycles
// - diagnostic read clears all but supply flags
// - persisting condition re-sets flag next sample
// - supply flags follow monitors, not read-cleared
// - bit 1 over-voltage, bit 0 under-voltage
// - alarm, overrange, serial, nvm flags at fixed bits
module smd_misc_diag (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe_n,
  input wire logic i_sample_tick,
  output logic o_io_line_one,
  output logic o_io_line_one_oe_n,
  output logic o_io_line_two,
  output logic o_io_line_two_oe_n,
  output logic o_stim_pos,
  output logic o_stim_neg,
  output logic o_st_measure,
  input wire logic i_st_result_valid,
  input wire logic i_st_result_pass,
  output logic o_memtest_req,
  input wire logic i_checksum_valid,
  input wire logic [15:0] i_nvm_checksum,
  input wire logic [15:0] i_ram_checksum,
  output logic [smd_pkg::DAC_W-1:0] o_dac_code,
  output logic o_nvm_update_req,
  input wire logic i_nvm_write_cycle,
  input wire logic i_nvm_fail,
  input wire logic i_overrange,
  input wire logic i_alarm1,
  input wire logic i_alarm2,
  input wire logic i_supply_high,
  input wire logic i_supply_low
);
  import smd_pkg::*;

  logic sclk_s, cs_n_s, din_s, sup_high_s, sup_low_s;

  smd_sync #(.W(5)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async({i_sclk, i_cs_n, i_din, i_supply_high, i_supply_low}),
    .i_reset_val(5'h18),
    .o_sync({sclk_s, cs_n_s, din_s, sup_high_s, sup_low_s})
  );

  // ---------------- serial link ----------------
  logic sclk_d_reg, sclk_d_next;
  logic cs_n_d_reg, cs_n_d_next;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [15:0] rx_reg, rx_next;
  logic [15:0] tx_reg, tx_next;
  logic [15:0] resp_reg, resp_next;
  logic dout_reg, dout_next;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic frame_ok, frame_bad, wr_frame, rd_frame;
  logic [6:0] frame_addr;
  logic [6:0] word_addr;
  logic [7:0] frame_data;
  logic [15:0] read_word;

  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign cs_fall = ~cs_n_s & cs_n_d_reg;
  assign cs_rise = cs_n_s & ~cs_n_d_reg;
  assign frame_ok = cs_rise && (bit_cnt_reg == FRAME_LEN);
  assign frame_bad = cs_rise && (bit_cnt_reg != FRAME_LEN)
                     && (bit_cnt_reg != 5'h00);
  assign wr_frame = frame_ok & rx_reg[FRAME_WRITE_BIT];
  assign rd_frame = frame_ok & ~rx_reg[FRAME_WRITE_BIT];
  assign frame_addr = rx_reg[FRAME_ADDR_HI:FRAME_ADDR_LO];
  assign word_addr = {frame_addr[6:1], 1'b0};
  assign frame_data = rx_reg[7:0];

  // mode 3: sample on the rising edge, shift out on the falling edge;
  // the first falling edge is skipped so bit 15 holds until sampled
  always_comb begin
    sclk_d_next = sclk_s;
    cs_n_d_next = cs_n_s;
    bit_cnt_next = bit_cnt_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    dout_next = dout_reg;
    resp_next = resp_reg;
    if (cs_fall) begin
      bit_cnt_next = 5'h00;
      dout_next = resp_reg[FRAME_BITS-1];
      tx_next = {resp_reg[14:0], 1'b0};
    end else if (!cs_n_s) begin
      if (sclk_rise) begin
        rx_next = {rx_reg[14:0], din_s};
        if (bit_cnt_reg != FRAME_CNT_MAX) begin
          bit_cnt_next = bit_cnt_reg + 5'h01;
        end
      end else if (sclk_fall && bit_cnt_reg != 5'h00) begin
        dout_next = tx_reg[FRAME_BITS-1];
        tx_next = {tx_reg[14:0], 1'b0};
      end
    end
    // a read answer goes out on the following frame
    if (rd_frame) begin
      resp_next = read_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sclk_d_reg <= 1'b1;
      cs_n_d_reg <= 1'b1;
      bit_cnt_reg <= 5'h00;
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      dout_reg <= 1'b0;
      resp_reg <= 16'h0000;
    end else if (i_ce) begin
      sclk_d_reg <= sclk_d_next;
      cs_n_d_reg <= cs_n_d_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      dout_reg <= dout_next;
      resp_reg <= resp_next;
    end
  end

  assign o_dout = dout_reg;
  assign o_dout_oe_n = cs_n_s;

  // ---------------- registers and test sequencer ----------------
  logic [15:0] misc_reg, misc_next;
  logic [15:0] dac_reg, dac_next;
  logic [DAC_W-1:0] dac_out_reg, dac_out_next;
  logic [15:0] nvm_cnt_reg, nvm_cnt_next;
  logic [15:0] diag_reg, diag_next;
  logic nvm_req_reg, nvm_req_next;
  logic mem_req_reg, mem_req_next;
  logic stim_pos_reg, stim_pos_next;
  logic stim_neg_reg, stim_neg_next;
  logic st_fail_reg, st_fail_next;
  smd_test_t test_reg, test_next;
  logic mem_done, mem_fail, st_done;
  logic [15:0] diag_view;

  assign diag_view = {diag_reg[15:2], sup_high_s, sup_low_s};

  always_comb begin
    unique case (word_addr)
      ADDR_NVM_CNT: read_word = nvm_cnt_reg;
      ADDR_DAC: read_word = dac_reg;
      ADDR_MISC: read_word = misc_reg;
      ADDR_DIAG: read_word = diag_view;
      default: read_word = 16'h0000;
    endcase
  end

  always_comb begin
    misc_next = misc_reg;
    dac_next = dac_reg;
    dac_out_next = dac_out_reg;
    nvm_cnt_next = nvm_cnt_reg;
    diag_next = diag_reg;
    nvm_req_next = 1'b0;
    mem_req_next = 1'b0;
    st_fail_next = st_fail_reg;
    test_next = test_reg;
    mem_done = 1'b0;
    mem_fail = 1'b0;
    st_done = 1'b0;

    if (wr_frame) begin
      if (word_addr == ADDR_MISC) begin
        if (!frame_addr[0]) begin
          misc_next[2:0] = frame_data[2:0];
        end else begin
          misc_next[MISC_ST_POS] = frame_data[0];
          misc_next[MISC_ST_NEG] = frame_data[1];
          // test bits only start here; clearing is the sequencer's job
          if (frame_data[2]) begin
            misc_next[MISC_SELFTEST] = 1'b1;
          end
          if (frame_data[3]) begin
            misc_next[MISC_MEMTEST] = 1'b1;
          end
        end
      end else if (word_addr == ADDR_DAC) begin
        if (!frame_addr[0]) begin
          dac_next[7:0] = frame_data;
        end else begin
          dac_next[15:8] = frame_data & DAC_MASK[15:8];
        end
      end else if (word_addr == ADDR_GCMD && !frame_addr[0]) begin
        if (frame_data[GCMD_DAC_LATCH]) begin
          dac_out_next = dac_reg[DAC_W-1:0];
        end
        nvm_req_next = frame_data[GCMD_NVM_UPDATE];
      end
    end

    if (i_nvm_write_cycle) begin
      nvm_cnt_next = nvm_cnt_reg + 16'h0001;
    end

    unique case (test_reg)
      TS_IDLE: begin
        st_fail_next = 1'b0;
        if (misc_reg[MISC_MEMTEST]) begin
          mem_req_next = 1'b1;
          test_next = TS_MEM_WAIT;
        end else if (misc_reg[MISC_SELFTEST]) begin
          test_next = TS_ST_POS;
        end
      end
      TS_MEM_WAIT: begin
        if (i_checksum_valid) begin
          mem_done = 1'b1;
          mem_fail = (i_nvm_checksum != i_ram_checksum);
          misc_next[MISC_MEMTEST] = 1'b0;
          test_next = TS_IDLE;
        end
      end
      TS_ST_POS: begin
        if (i_st_result_valid) begin
          st_fail_next = st_fail_reg | ~i_st_result_pass;
          test_next = TS_ST_NEG;
        end
      end
      TS_ST_NEG: begin
        if (i_st_result_valid) begin
          st_fail_next = st_fail_reg | ~i_st_result_pass;
          test_next = TS_ST_DONE;
        end
      end
      TS_ST_DONE: begin
        // stimulus already released: normal operation is back
        st_done = 1'b1;
        misc_next[MISC_SELFTEST] = 1'b0;
        test_next = TS_IDLE;
      end
    endcase

    // clear first, then let any set in the same cycle win
    if (rd_frame && word_addr == ADDR_DIAG) begin
      diag_next = diag_reg & ~DIAG_STICKY_MASK;
    end
    if (i_sample_tick) begin
      if (i_alarm2) diag_next[DIAG_ALARM2] = 1'b1;
      if (i_alarm1) diag_next[DIAG_ALARM1] = 1'b1;
      if (i_overrange) diag_next[DIAG_OVERRANGE] = 1'b1;
      if (i_nvm_fail) diag_next[DIAG_NVM_FAIL] = 1'b1;
    end
    if (frame_bad) begin
      diag_next[DIAG_SPI_FAIL] = 1'b1;
    end
    if (mem_done) begin
      diag_next[DIAG_MEMTEST] = mem_fail;
    end
    if (st_done) begin
      diag_next[DIAG_SELFTEST] = st_fail_reg;
    end
    // supply flags live outside the sticky register
    diag_next[DIAG_SUP_HIGH] = 1'b0;
    diag_next[DIAG_SUP_LOW] = 1'b0;

    stim_pos_next = misc_next[MISC_ST_POS] || test_next == TS_ST_POS;
    stim_neg_next = misc_next[MISC_ST_NEG] || test_next == TS_ST_NEG;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      misc_reg <= MISC_RESET;
      dac_reg <= DAC_RESET;
      dac_out_reg <= DAC_RESET[DAC_W-1:0];
      nvm_cnt_reg <= NVM_CNT_RESET;
      diag_reg <= DIAG_RESET;
      nvm_req_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      stim_pos_reg <= 1'b0;
      stim_neg_reg <= 1'b0;
      st_fail_reg <= 1'b0;
      test_reg <= TS_IDLE;
    end else if (i_ce) begin
      misc_reg <= misc_next;
      dac_reg <= dac_next;
      dac_out_reg <= dac_out_next;
      nvm_cnt_reg <= nvm_cnt_next;
      diag_reg <= diag_next;
      nvm_req_reg <= nvm_req_next;
      mem_req_reg <= mem_req_next;
      stim_pos_reg <= stim_pos_next;
      stim_neg_reg <= stim_neg_next;
      st_fail_reg <= st_fail_next;
      test_reg <= test_next;
    end
  end

  assign o_stim_pos = stim_pos_reg;
  assign o_stim_neg = stim_neg_reg;
  assign o_st_measure = (test_reg == TS_ST_POS) || (test_reg == TS_ST_NEG);
  assign o_memtest_req = mem_req_reg;
  assign o_dac_code = dac_out_reg;
  assign o_nvm_update_req = nvm_req_reg;

  // ---------------- data-ready pulse ----------------
  logic [DRDY_CNT_W-1:0] dr_cnt_reg, dr_cnt_next;
  logic io1_reg, io1_next, io1_oe_n_reg, io1_oe_n_next;
  logic io2_reg, io2_next, io2_oe_n_reg, io2_oe_n_next;
  logic dr_active, dr_level;

  // pulse sits in the middle of the window to leave margin both ways
  always_comb begin
    dr_cnt_next = dr_cnt_reg;
    if (!misc_reg[MISC_DR_EN]) begin
      dr_cnt_next = DRDY_CNT_ZERO;
    end else if (i_sample_tick) begin
      dr_cnt_next = DRDY_PULSE_CYC;
    end else if (dr_cnt_reg != DRDY_CNT_ZERO) begin
      dr_cnt_next = dr_cnt_reg - 12'h001;
    end
    dr_active = (dr_cnt_next != DRDY_CNT_ZERO);
    dr_level = ~(dr_active ^ misc_next[MISC_DR_POL]);
    io1_next = 1'b0;
    io2_next = 1'b0;
    io1_oe_n_next = 1'b1;
    io2_oe_n_next = 1'b1;
    if (misc_next[MISC_DR_EN]) begin
      if (misc_next[MISC_DR_LINE]) begin
        io2_next = dr_level;
        io2_oe_n_next = 1'b0;
      end else begin
        io1_next = dr_level;
        io1_oe_n_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dr_cnt_reg <= DRDY_CNT_ZERO;
      io1_reg <= 1'b0;
      io2_reg <= 1'b0;
      io1_oe_n_reg <= 1'b1;
      io2_oe_n_reg <= 1'b1;
    end else if (i_ce) begin
      dr_cnt_reg <= dr_cnt_next;
      io1_reg <= io1_next;
      io2_reg <= io2_next;
      io1_oe_n_reg <= io1_oe_n_next;
      io2_oe_n_reg <= io2_oe_n_next;
    end
  end

  assign o_io_line_one = io1_reg;
  assign o_io_line_one_oe_n = io1_oe_n_reg;
  assign o_io_line_two = io2_reg;
  assign o_io_line_two_oe_n = io2_oe_n_reg;
endmodule

/* File: smd_host.sv */
module smd_host (
  input wire logic i_clk,
  input wire logic i_dout,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  output logic o_done,
  output logic [15:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din = 1'b0;
    o_done = 1'b0;
    o_rx = 16'h0000;
  end
  // clock parks high between frames; a short count makes a refused frame
  task automatic xfer(input logic [15:0] tx, input int nb);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    for (int b = 15; b > 15 - nb; b--) begin
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
      o_din <= tx[b];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      o_rx[b] <= i_dout;
    end
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    // released line: no pull, so show the inverse rather than a held level
    o_din <= ~o_din;
    o_done <= 1'b1;
    @(posedge i_clk);
    o_done <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

/* File: smd_misc_diag_props.sv */
module smd_misc_diag_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sample_tick,
  input wire logic o_dout_oe_n,
  input wire logic o_io_line_one,
  input wire logic o_io_line_one_oe_n,
  input wire logic o_io_line_two_oe_n,
  input wire logic o_stim_pos,
  input wire logic o_stim_neg,
  input wire logic o_st_measure,
  input wire logic o_memtest_req,
  input wire logic [smd_pkg::DAC_W-1:0] o_dac_code,
  input wire logic o_nvm_update_req
);
  logic [11:0] since_cs;
  logic [11:0] run;
  logic wr_near;
  // age of the open ready pulse, counted instead of a long delay range
  logic [11:0] pulse_age;
  logic pulse_open;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pulse_age <= 12'h000;
      pulse_open <= 1'b0;
    end else if ($changed(o_io_line_one) && !o_io_line_one_oe_n
                 && $past(i_sample_tick)) begin
      pulse_age <= 12'h000;
      pulse_open <= 1'b1;
    end else begin
      if (pulse_age != 12'hFFF) pulse_age <= pulse_age + 12'h001;
      if ($changed(o_io_line_one) || i_sample_tick || !i_cs_n) begin
        pulse_open <= 1'b0;
      end
    end
  end
  // register writes land a few clocks after select rises
  assign wr_near = since_cs <= 12'h008;
  always_ff @(posedge i_clk) begin
    if (i_rst || $rose(i_cs_n)) since_cs <= 12'h000;
    else if (since_cs != 12'hFFF) since_cs <= since_cs + 12'h001;
    if (i_rst || $changed(o_io_line_one)) run <= 12'h000;
    else if (run != 12'hFFF) run <= run + 12'h001;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_oe;
    $stable(i_cs_n) [*4] |-> o_dout_oe_n == i_cs_n;
  endproperty
  a_oe: assert property (p_oe)
    else $error("serial enable does not follow select");
  property p_one_line;
    !o_io_line_one_oe_n |-> o_io_line_two_oe_n;
  endproperty
  a_one_line: assert property (p_one_line)
    else $error("both lines driven");
  property p_drdy_min;
    $changed(o_io_line_one) && !o_io_line_one_oe_n
      && !$past(o_io_line_one_oe_n) |-> $past(i_sample_tick)
      || $past(i_sample_tick, 2) || wr_near || run >= 12'h7CF;
  endproperty
  a_drdy_min: assert property (p_drdy_min)
    else $error("ready pulse too short");
  property p_drdy_max;
    pulse_open |-> pulse_age <= 12'hF9E;
  endproperty
  a_drdy_max: assert property (p_drdy_max)
    else $error("ready pulse too long");
  property p_meas;
    o_st_measure |-> o_stim_pos || o_stim_neg;
  endproperty
  a_meas: assert property (p_meas)
    else $error("measuring without stimulus");
  property p_mem;
    $rose(o_memtest_req) |-> wr_near ##1 !o_memtest_req;
  endproperty
  a_mem: assert property (p_mem)
    else $error("memory test request out of place");
  property p_dac;
    $changed(o_dac_code) |-> wr_near;
  endproperty
  a_dac: assert property (p_dac)
    else $error("analog code moved without a command");
  property p_nvm;
    o_nvm_update_req |-> wr_near ##1 !o_nvm_update_req;
  endproperty
  a_nvm: assert property (p_nvm)
    else $error("update request out of place");
  property p_stim;
    ($changed(o_stim_pos) || $changed(o_stim_neg)) && !o_st_measure
      && !$past(o_st_measure) |-> wr_near;
  endproperty
  a_stim: assert property (p_stim)
    else $error("stimulus moved without a write");
endmodule
bind smd_misc_diag smd_misc_diag_props i_props (.i_clk, .i_rst, .i_cs_n,
  .i_sample_tick, .o_dout_oe_n, .o_io_line_one, .o_io_line_one_oe_n,
  .o_io_line_two_oe_n, .o_stim_pos, .o_stim_neg, .o_st_measure,
  .o_memtest_req, .o_dac_code, .o_nvm_update_req);

/* File: smd_misc_diag_bench.sv */
module smd_misc_diag_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import smd_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_sample_tick = 1'b0;
  logic i_st_result_valid = 1'b0, i_st_result_pass = 1'b0;
  logic i_checksum_valid = 1'b0, i_nvm_write_cycle = 1'b0;
  logic [15:0] i_nvm_checksum = 16'h0000, i_ram_checksum = 16'h0000;
  logic i_nvm_fail = 1'b0, i_overrange = 1'b0, i_alarm1 = 1'b0;
  logic i_alarm2 = 1'b0, i_supply_high = 1'b0, i_supply_low = 1'b0;
  logic i_sclk, i_cs_n, i_din, o_dout, o_dout_oe_n, miso, done, ph = 1'b0;
  logic o_io_line_one, o_io_line_one_oe_n, o_io_line_two, o_io_line_two_oe_n;
  logic o_stim_pos, o_stim_neg, o_st_measure, o_memtest_req;
  logic o_nvm_update_req, st_fail = 1'b0;
  logic [DAC_W-1:0] o_dac_code;
  logic [15:0] rx, code, ck;
  logic [15:0] exp_q[$];
  string nm_q[$];
  int miscompares = 0, n_tests = 0, wt = 0, n;
  logic [2:0] cfgs[4] = '{3'h6, 3'h5, 3'h7, 3'h4};
  logic [1:0] stims[4] = '{2'h2, 2'h1, 2'h3, 2'h0};
  initial forever #25 i_clk = ~i_clk;
  assign miso = o_dout_oe_n ? ~o_dout : o_dout;
  smd_misc_diag i_smd_misc_diag (.i_clk, .i_rst, .i_ce(1'b1), .i_sclk,
    .i_cs_n, .i_din, .o_dout, .o_dout_oe_n, .i_sample_tick, .o_io_line_one,
    .o_io_line_one_oe_n, .o_io_line_two, .o_io_line_two_oe_n, .o_stim_pos,
    .o_stim_neg, .o_st_measure, .i_st_result_valid, .i_st_result_pass,
    .o_memtest_req, .i_checksum_valid, .i_nvm_checksum, .i_ram_checksum,
    .o_dac_code, .o_nvm_update_req, .i_nvm_write_cycle, .i_nvm_fail,
    .i_overrange, .i_alarm1, .i_alarm2, .i_supply_high, .i_supply_low);
  smd_host i_smd_host (.i_clk, .i_dout(miso), .o_sclk(i_sclk),
    .o_cs_n(i_cs_n), .o_din(i_din), .o_done(done), .o_rx(rx));
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    i_smd_host.xfer({1'b1, a, d}, 16);
  endtask
  // the answer to a read comes back in the following frame
  task automatic rd(logic [6:0] a, logic [15:0] e, string nm);
    i_smd_host.xfer({1'b0, a, 8'h00}, 16);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    i_smd_host.xfer(16'h0000, 16);
  endtask
  task automatic tick;
    @(posedge i_clk);
    i_sample_tick <= 1'b1;
    @(posedge i_clk);
    i_sample_tick <= 1'b0;
  endtask
  task automatic pulse(logic two, logic act);
    int w = 0;
    tick();
    repeat (2) @(posedge i_clk);
    while ((two ? o_io_line_two : o_io_line_one) === act && w < 5000) begin
      @(posedge i_clk);
      w++;
    end
    chk("pulse ok", 16'h0001, {15'h0000, w >= 1998 && w <= 4000});
    n = two ? o_io_line_one_oe_n : o_io_line_two_oe_n;
    chk("other line", 16'h0001, 16'(n));
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge i_clk)
    if (done === 1'b1 && exp_q.size() > 0)
      chk(nm_q.pop_front(), exp_q.pop_front(), rx);
  // sensor side stub: each stimulus phase answers after twenty clocks
  always @(posedge i_clk) begin
    i_checksum_valid <= o_memtest_req;
    if (o_memtest_req === 1'b1) begin
      ck = 16'($urandom);
      i_nvm_checksum <= ck;
      i_ram_checksum <= ck ^ {15'h0000, st_fail};
    end
    i_st_result_valid <= 1'b0;
    if (o_st_measure === 1'b1 && !i_st_result_valid) wt <= wt + 1;
    if (wt == 20) begin
      chk("phase", {14'h0000, ph, !ph}, {14'h0000, o_stim_neg, o_stim_pos});
      ph <= !ph;
      wt <= 0;
      i_st_result_valid <= 1'b1;
      i_st_result_pass <= !st_fail;
    end
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    miscompares++;
    $display("unexpected run length: expected end, seen hang");
    report_and_stop();
  end
  initial begin
    void'($urandom(93180));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(ADDR_MISC, MISC_RESET, "misc");
    rd(ADDR_DAC, DAC_RESET, "code");
    wr(ADDR_NVM_CNT, 8'hFF);
    rd(ADDR_NVM_CNT, NVM_CNT_RESET, "count");
    rd(ADDR_DIAG, DIAG_RESET, "flags");
    rd(7'h10, 16'h0000, "unmapped");
    $display("test reset done");
    foreach (cfgs[k]) begin
      wr(ADDR_MISC, {5'h00, cfgs[k]});
      pulse(cfgs[k][0], cfgs[k][1]);
    end
    wr(ADDR_MISC, 8'h00);
    chk("released", 16'h0003, {14'h0000, o_io_line_one_oe_n, o_io_line_two_oe_n});
    wr(ADDR_MISC, 8'h06);
    $display("test ready done");
    code = 16'($urandom);
    wr(ADDR_DAC + 7'h01, code[15:8]);
    wr(ADDR_DAC, code[7:0]);
    chk("code held", 16'h0000, {4'h0, o_dac_code});
    wr(ADDR_GCMD, 8'h04);
    chk("code out", code & DAC_MASK, {4'h0, o_dac_code});
    rd(ADDR_DAC, code & DAC_MASK, "code reg");
    rd(ADDR_GCMD, 16'h0000, "command");
    n = $urandom_range(20, 1);
    i_nvm_write_cycle <= 1'b1;
    repeat (n) @(posedge i_clk);
    i_nvm_write_cycle <= 1'b0;
    wr(ADDR_GCMD, 8'h08);
    rd(ADDR_NVM_CNT, 16'(n), "count");
    $display("test code and count done");
    {i_alarm2, i_alarm1, i_overrange, i_nvm_fail} <= 4'hF;
    i_supply_high <= 1'b1;
    tick();
    rd(ADDR_DIAG, 16'h0316, "flags");
    {i_alarm2, i_overrange, i_nvm_fail} <= 3'h0;
    rd(ADDR_DIAG, 16'h0002, "cleared");
    tick();
    rd(ADDR_DIAG, 16'h0102, "again");
    {i_alarm1, i_supply_high, i_supply_low} <= 3'h1;
    rd(ADDR_DIAG, 16'h0001, "low supply");
    i_supply_low <= 1'b0;
    rd(ADDR_DIAG, 16'h0000, "supply back");
    i_smd_host.xfer(16'hB400, 8);
    rd(ADDR_DIAG, 16'h0008, "bad frame");
    rd(ADDR_MISC, MISC_RESET, "misc kept");
    $display("test flags done");
    foreach (stims[k]) begin
      wr(ADDR_MISC + 7'h01, {6'h00, stims[k]});
      chk("stimulus", {14'h0000, stims[k]}, {14'h0000, o_stim_neg, o_stim_pos});
    end
    for (int f = 1; f >= 0; f--) begin
      st_fail <= f[0];
      wr(ADDR_MISC + 7'h01, 8'h08);
      rd(ADDR_MISC, MISC_RESET, "mem bit");
      rd(ADDR_DIAG, {9'h000, f[0], 6'h00}, "mem flag");
      wr(ADDR_MISC + 7'h01, 8'h04);
      rd(ADDR_MISC, MISC_RESET, "self bit");
      rd(ADDR_DIAG, {10'h000, f[0], 5'h00}, "self flag");
    end
    $display("test tests done");
    report_and_stop();
  end
endmodule
